// >>> tpgwc_timer.v
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/10ps
`include "tpgwc_consts.vh"
module tpgwc_timer (
  // APB clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Trigger inputs
  input  wire        primary_trigger_input,
  input  wire        secondary_trigger_input,
  // Timer output and events
  output wire        timer_output_pin,
  output wire        period_match_interrupt,
  output wire        width_match_interrupt
);
  reg  [1:0]  mode_q;
  reg  [3:0]  output_control_q;
  reg  [6:0]  cap_ctl_q;
  reg  [15:0] up_counter_q;
  reg  [15:0] up_counter_d;
  reg  [15:0] period_register_q;
  reg  [15:0] width_register_q;
  reg         overflow_flag_q;
  reg         per_ev_q;
  reg         wid_ev_q;
  reg         out_q;
  reg         per_irq_q;
  reg         wid_irq_q;
  reg         per_irq_d;
  reg         wid_irq_d;
  reg         out_d;
  reg         addr_ok;

  wire wr_en;
  wire rd_en;
  wire running;
  wire p_valid;
  wire p_opp;
  wire s_valid;
  wire per_match;
  wire wid_match;
  wire oneshot_ok;
  wire soft_trig;
  wire os_trig;
  wire per_cap_ev;
  wire wid_cap_ev;
  wire clr_ovf;
  wire clr_per_ev;
  wire clr_wid_ev;
  // One select per mapped word, used only by the error answer; the read and write decode compare paddr directly
  wire sel_mode;
  wire sel_outctl;
  wire sel_capctl;
  wire sel_status;
  wire sel_count;
  wire sel_period;
  wire sel_width;
  wire sel_softtrig;

  function is_addr;
    input [11:0] a;
    input [11:0] off;
    begin
      is_addr = (a == off);
    end
  endfunction

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign running = (mode_q != `TPGWC_MODE_STOP);

  assign sel_mode     = is_addr(paddr, `TPGWC_OFF_MODE);
  assign sel_outctl   = is_addr(paddr, `TPGWC_OFF_OUTCTL);
  assign sel_capctl   = is_addr(paddr, `TPGWC_OFF_CAPCTL);
  assign sel_status   = is_addr(paddr, `TPGWC_OFF_STATUS);
  assign sel_count    = is_addr(paddr, `TPGWC_OFF_COUNT);
  assign sel_period   = is_addr(paddr, `TPGWC_OFF_PERIOD);
  assign sel_width    = is_addr(paddr, `TPGWC_OFF_WIDTH);
  assign sel_softtrig = is_addr(paddr, `TPGWC_OFF_SOFTTRIG);

  // Anything outside the eight words is answered with a slave error
  always @* begin
    addr_ok = 1'b0;
    if (sel_mode) begin
      addr_ok = 1'b1;
    end else if (sel_outctl) begin
      addr_ok = 1'b1;
    end else if (sel_capctl) begin
      addr_ok = 1'b1;
    end else if (sel_status) begin
      addr_ok = 1'b1;
    end else if (sel_count) begin
      addr_ok = 1'b1;
    end else if (sel_period) begin
      addr_ok = 1'b1;
    end else if (sel_width) begin
      addr_ok = 1'b1;
    end else if (sel_softtrig) begin
      addr_ok = 1'b1;
    end
  end

  tpgwc_edge_det u_pri (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_in     (primary_trigger_input),
    .sel_rise   (cap_ctl_q[`TPGWC_CC_P_RISE]),
    .sel_fall   (cap_ctl_q[`TPGWC_CC_P_FALL]),
    .valid_edge (p_valid),
    .opp_edge   (p_opp)
  );

  tpgwc_edge_det u_sec (
    .pclk       (pclk),
    .presetn    (presetn),
    .pin_in     (secondary_trigger_input),
    .sel_rise   (cap_ctl_q[`TPGWC_CC_S_RISE]),
    .sel_fall   (cap_ctl_q[`TPGWC_CC_S_FALL]),
    .valid_edge (s_valid),
    .opp_edge   ()
  );

  assign per_match  = running & (up_counter_q == period_register_q);
  assign wid_match  = running & (up_counter_q == width_register_q);
  // One-shot is refused in match-clear mode
  assign oneshot_ok = output_control_q[`TPGWC_OC_ONESHOT] &
                      ((mode_q == `TPGWC_MODE_FREE) || (mode_q == `TPGWC_MODE_EDGE));
  assign soft_trig  = wr_en & is_addr(paddr, `TPGWC_OFF_SOFTTRIG) & pwdata[0];
  // A retrigger mid-pulse simply restarts; keeping spacing is software's job
  assign os_trig    = oneshot_ok & running & (soft_trig | p_valid);

  // Period source: secondary valid edge, or primary opposite phase
  assign per_cap_ev = running & cap_ctl_q[`TPGWC_CC_PER_CAP] &
                      (cap_ctl_q[`TPGWC_CC_PER_SRC] ? p_opp : s_valid);
  assign wid_cap_ev = running & cap_ctl_q[`TPGWC_CC_WID_CAP] & p_valid;

  assign clr_ovf    = wr_en & is_addr(paddr, `TPGWC_OFF_STATUS) & pwdata[`TPGWC_ST_OVF];
  assign clr_per_ev = wr_en & is_addr(paddr, `TPGWC_OFF_STATUS) & pwdata[`TPGWC_ST_PER_EV];
  assign clr_wid_ev = wr_en & is_addr(paddr, `TPGWC_OFF_STATUS) & pwdata[`TPGWC_ST_WID_EV];

  always @* begin
    up_counter_d = up_counter_q;
    if (!running) begin
      up_counter_d = `TPGWC_CNT_RST;
    end else if (os_trig) begin
      up_counter_d = `TPGWC_CNT_RST;
    end else if ((mode_q == `TPGWC_MODE_EDGE) && p_valid) begin
      up_counter_d = `TPGWC_CNT_RST;
    end else if ((mode_q == `TPGWC_MODE_MATCH) && per_match) begin
      up_counter_d = `TPGWC_CNT_RST;
    end else begin
      up_counter_d = up_counter_q + 16'h0001;
    end
  end

  always @* begin
    out_d     = out_q;
    per_irq_d = 1'b0;
    wid_irq_d = 1'b0;
    if (!running) begin
      out_d = 1'b0;
    end else begin
      // Compare interrupts only when the register is not capturing
      if (per_match && !cap_ctl_q[`TPGWC_CC_PER_CAP]) begin
        per_irq_d = 1'b1;
      end
      if (wid_match && !cap_ctl_q[`TPGWC_CC_WID_CAP]) begin
        wid_irq_d = 1'b1;
      end
      if (wid_cap_ev) begin
        wid_irq_d = 1'b1;
      end
      if (per_cap_ev && !cap_ctl_q[`TPGWC_CC_PER_SRC]) begin
        per_irq_d = 1'b1;
      end
      if (mode_q == `TPGWC_MODE_MATCH) begin
        // High from restart through width match, low until period match
        if (per_match) begin
          out_d = 1'b1;
        end else if (wid_match) begin
          out_d = 1'b0;
        end
      end else if (output_control_q[`TPGWC_OC_ENABLE]) begin
        if (os_trig) begin
          out_d = 1'b0;
        end else if (per_match && output_control_q[`TPGWC_OC_PER_INV] &&
                     !cap_ctl_q[`TPGWC_CC_PER_CAP]) begin
          out_d = ~out_q;
          if (wid_match && output_control_q[`TPGWC_OC_WID_INV]) begin
            out_d = out_q;
          end
        end else if (wid_match && output_control_q[`TPGWC_OC_WID_INV] &&
                     !cap_ctl_q[`TPGWC_CC_WID_CAP]) begin
          out_d = ~out_q;
        end
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q            <= `TPGWC_MODE_STOP;
      output_control_q  <= 4'h0;
      cap_ctl_q         <= 7'h00;
      up_counter_q      <= `TPGWC_CNT_RST;
      period_register_q <= 16'h0000;
      width_register_q  <= 16'h0000;
      out_q             <= 1'b0;
      per_irq_q         <= 1'b0;
      wid_irq_q         <= 1'b0;
    end else begin
      up_counter_q <= up_counter_d;
      out_q        <= out_d;
      per_irq_q    <= per_irq_d;
      wid_irq_q    <= wid_irq_d;
      if (wr_en && is_addr(paddr, `TPGWC_OFF_MODE)) begin
        mode_q <= pwdata[1:0];
      end
      if (wr_en && is_addr(paddr, `TPGWC_OFF_OUTCTL)) begin
        output_control_q <= pwdata[3:0];
      end
      if (wr_en && is_addr(paddr, `TPGWC_OFF_CAPCTL)) begin
        cap_ctl_q <= pwdata[6:0];
      end
      // Capture wins over a software write in the same cycle
      if (per_cap_ev) begin
        period_register_q <= up_counter_q;
      end else if (wr_en && is_addr(paddr, `TPGWC_OFF_PERIOD)) begin
        period_register_q <= pwdata[15:0];
      end
      if (wid_cap_ev) begin
        width_register_q <= up_counter_q;
      end else if (wr_en && is_addr(paddr, `TPGWC_OFF_WIDTH)) begin
        width_register_q <= pwdata[15:0];
      end
    end
  end

  // Set wins over clear, so a wrap in the clearing cycle is not lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_q <= 1'b0;
    end else begin
      if (running && (up_counter_q == `TPGWC_CNT_MAX) && (up_counter_d == `TPGWC_CNT_RST)) begin
        overflow_flag_q <= 1'b1;
      end else if (clr_ovf) begin
        overflow_flag_q <= 1'b0;
      end
    end
  end

  // Sticky copy of the period event for polling software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_ev_q <= 1'b0;
    end else begin
      if (per_irq_d) begin
        per_ev_q <= 1'b1;
      end else if (clr_per_ev) begin
        per_ev_q <= 1'b0;
      end
    end
  end

  // Sticky copy of the width event for polling software
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wid_ev_q <= 1'b0;
    end else begin
      if (wid_irq_d) begin
        wid_ev_q <= 1'b1;
      end else if (clr_wid_ev) begin
        wid_ev_q <= 1'b0;
      end
    end
  end

  always @* begin
    prdata = 32'h00000000;
    if (rd_en) begin
      if (is_addr(paddr, `TPGWC_OFF_MODE)) begin
        prdata = {30'h00000000, mode_q};
      end else if (is_addr(paddr, `TPGWC_OFF_OUTCTL)) begin
        prdata = {28'h0000000, output_control_q};
      end else if (is_addr(paddr, `TPGWC_OFF_CAPCTL)) begin
        prdata = {25'h0000000, cap_ctl_q};
      end else if (is_addr(paddr, `TPGWC_OFF_STATUS)) begin
        prdata = {29'h00000000, wid_ev_q, per_ev_q, overflow_flag_q};
      end else if (is_addr(paddr, `TPGWC_OFF_COUNT)) begin
        prdata = {16'h0000, up_counter_q};
      end else if (is_addr(paddr, `TPGWC_OFF_PERIOD)) begin
        prdata = {16'h0000, period_register_q};
      end else if (is_addr(paddr, `TPGWC_OFF_WIDTH)) begin
        prdata = {16'h0000, width_register_q};
      end
    end
  end

  assign timer_output_pin       = out_q;
  assign period_match_interrupt = per_irq_q;
  assign width_match_interrupt  = wid_irq_q;
endmodule // tpgwc_timer

// >>> tpgwc_consts.vh
`ifndef TPGWC_CONSTS_VH
`define TPGWC_CONSTS_VH
// Register byte offsets
`define TPGWC_OFF_MODE     12'h000
`define TPGWC_OFF_OUTCTL   12'h004
`define TPGWC_OFF_CAPCTL   12'h008
`define TPGWC_OFF_STATUS   12'h00C
`define TPGWC_OFF_COUNT    12'h010
`define TPGWC_OFF_PERIOD   12'h014
`define TPGWC_OFF_WIDTH    12'h018
`define TPGWC_OFF_SOFTTRIG 12'h01C
// Mode select encodings
`define TPGWC_MODE_STOP    2'h0
`define TPGWC_MODE_FREE    2'h1
`define TPGWC_MODE_EDGE    2'h2
`define TPGWC_MODE_MATCH   2'h3
// Output control fields
`define TPGWC_OC_PER_INV   0
`define TPGWC_OC_WID_INV   1
`define TPGWC_OC_ONESHOT   2
`define TPGWC_OC_ENABLE    3
// Capture control fields
`define TPGWC_CC_PER_CAP   0
`define TPGWC_CC_PER_SRC   1
`define TPGWC_CC_WID_CAP   2
`define TPGWC_CC_P_RISE    3
`define TPGWC_CC_P_FALL    4
`define TPGWC_CC_S_RISE    5
`define TPGWC_CC_S_FALL    6
// Status fields
`define TPGWC_ST_OVF       0
`define TPGWC_ST_PER_EV    1
`define TPGWC_ST_WID_EV    2
// Reset values and limits
`define TPGWC_CNT_RST      16'h0000
`define TPGWC_CNT_MAX      16'hFFFF
`endif

// >>> tpgwc_edge_det.v
`timescale 1ns/10ps
// Edge detector for one trigger input; opposite edge reported separately
module tpgwc_edge_det (
  // Clock and reset
  input  wire pclk,
  input  wire presetn,
  // Input and edge selection
  input  wire pin_in,
  input  wire sel_rise,
  input  wire sel_fall,
  // Events
  output wire valid_edge,
  output wire opp_edge
);
  reg  prev_q;
  wire rise;
  wire fall;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin_in;
    end
  end

  assign rise       = pin_in & ~prev_q;
  assign fall       = ~pin_in & prev_q;
  assign valid_edge = (rise & sel_rise) | (fall & sel_fall);
  // Opposite phase only makes sense for a single selected edge
  assign opp_edge   = (rise & sel_fall & ~sel_rise) | (fall & sel_rise & ~sel_fall);
endmodule // tpgwc_edge_det

// >>> tpgwc_timer_monitor.sv
`timescale 1ns/10ps
module tpgwc_timer_monitor (
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Pins and events
  input wire        primary_trigger_input,
  input wire        secondary_trigger_input,
  input wire        timer_output_pin,
  input wire        period_match_interrupt,
  input wire        width_match_interrupt
);
  reg  [1:0] mode_q;
  reg  [6:0] cc_q;
  reg        os_q;
  wire       acc = psel && penable;
  wire       wr  = acc && pwrite;
  wire       rdc = acc && !pwrite && paddr == 12'h010;
  wire       run = mode_q == 2'h1 || mode_q == 2'h2;
  // Shadow copy of the controls, updated at the same edge as the design
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
      cc_q   <= 7'h00;
      os_q   <= 1'b0;
    end else if (wr) begin
      if (paddr == 12'h000) mode_q <= pwdata[1:0];
      if (paddr == 12'h004) os_q <= pwdata[2];
      if (paddr == 12'h008) cc_q <= pwdata[6:0];
    end
  end
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_STOP_READ0: assert property (rdc && mode_q == 2'h0 |-> prdata == 32'h0)
    else $error("count not zero while stopped");
  AST_CNT_STEP: assert property ((rdc && mode_q == 2'h1 ##2 rdc && mode_q == 2'h1)
    |-> prdata[15:0] == $past(prdata[15:0], 2) + 16'h0002) else $error("count step wrong");
  AST_WID_EDGE: assert property (run && cc_q[2] && cc_q[3] && $rose(primary_trigger_input)
    |-> ##[1:4] width_match_interrupt) else $error("no width event after edge");
  AST_OPP_QUIET: assert property (run && cc_q[1:0] == 2'h3 && cc_q[6:5] == 2'h0
    |-> !period_match_interrupt) else $error("period event on opposite capture");
  AST_PER_PULSE: assert property (period_match_interrupt |=> !period_match_interrupt)
    else $error("period event too long");
  AST_WID_PULSE: assert property (width_match_interrupt |=> !width_match_interrupt)
    else $error("width event too long");
  AST_OS_START: assert property (wr && paddr == 12'h01C && pwdata[0] && os_q && run
    |-> ##2 !timer_output_pin) else $error("one-shot start not low");
  AST_UNMAPPED: assert property (acc && paddr > 12'h01C |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule // tpgwc_timer_monitor
bind tpgwc_timer tpgwc_timer_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .primary_trigger_input(primary_trigger_input),
  .secondary_trigger_input(secondary_trigger_input), .timer_output_pin(timer_output_pin),
  .period_match_interrupt(period_match_interrupt),
  .width_match_interrupt(width_match_interrupt));

// >>> tpgwc_pulse_src.sv
`timescale 1ns/10ps
module tpgwc_pulse_src (
  // Clock and command
  input  wire       pclk,
  input  wire       go,
  input  wire [7:0] hi_len,
  input  wire [7:0] lo_len,
  input  wire [3:0] reps,
  // Trigger lines
  output reg        prim,
  output wire       sec
);
  reg [4:0] dly_q = 5'h00;
  integer   k;
  initial prim = 1'b0;
  // Secondary line trails the primary by five clocks
  assign sec = dly_q[4];
  always @(posedge pclk) begin
    dly_q <= {dly_q[3:0], prim};
  end
  // Levels are held hi_len and lo_len clocks; the test uses four or more so each edge is seen
  always @(posedge go) begin
    for (k = 0; k < reps; k = k + 1) begin
      prim <= 1'b1;
      repeat (hi_len) @(posedge pclk);
      prim <= 1'b0;
      repeat (lo_len) @(posedge pclk);
    end
  end
endmodule // tpgwc_pulse_src

// >>> timer_pulse_gen_and_width_capture_test.sv
`timescale 1ns/10ps
`include "tpgwc_consts.vh"
module timer_pulse_gen_and_width_capture_test;
  typedef struct packed {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] e; logic s;} tpgwc_row_t;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         go = 1'b0;
  reg  [7:0]  hi_len = 8'h04;
  reg  [7:0]  lo_len = 8'h04;
  reg  [3:0]  reps = 4'h1;
  wire [31:0] prdata;
  wire        pready, pslverr, prim, sec, tout, pirq, wirq;
  reg  [31:0] rd;
  reg         er;
  integer     errors = 0;
  integer     total_checks = 0;
  integer     i, hi, lo;
  tpgwc_row_t rows [0:5];
  always #25 pclk = ~pclk;
  tpgwc_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .primary_trigger_input(prim), .secondary_trigger_input(sec),
    .timer_output_pin(tout), .period_match_interrupt(pirq), .width_match_interrupt(wirq));
  tpgwc_pulse_src u_src (.pclk(pclk), .go(go), .hi_len(hi_len), .lo_len(lo_len),
    .reps(reps), .prim(prim), .sec(sec));
  task apb(input [11:0] a, input w, input [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
    end
  endtask
  task idle;
    begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      apb(a, 1'b1, d);
      idle;
    end
  endtask
  task rdi(input [11:0] a);
    begin
      apb(a, 1'b0, 32'h0);
      idle;
    end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        $display("[FAIL] %0s expected %h seen %h", n, e, g);
        errors = errors + 1;
      end
    end
  endtask
  // Waits until the output is high, then times the high and the low part
  task meas;
    begin
      i = 0;
      while (tout !== 1'b1 && i < 300) begin
        @(posedge pclk);
        i = i + 1;
      end
      hi = 0;
      while (tout === 1'b1 && hi < 300) begin
        @(posedge pclk);
        hi = hi + 1;
      end
      lo = 0;
      while (tout !== 1'b1 && lo < 300) begin
        @(posedge pclk);
        lo = lo + 1;
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    repeat (80000) @(posedge pclk);
    errors = errors + 1;
    finish_test;
  end
  initial begin
    rows[0] = {`TPGWC_OFF_PERIOD, 1'b1, 32'h0000_1234, 32'h0000_1234, 1'b0};
    rows[1] = {`TPGWC_OFF_WIDTH, 1'b1, 32'h0001_ABCD, 32'h0000_ABCD, 1'b0};
    rows[2] = {`TPGWC_OFF_COUNT, 1'b1, 32'h0000_0077, 32'h0, 1'b0};
    rows[3] = {`TPGWC_OFF_SOFTTRIG, 1'b1, 32'h0, 32'h0, 1'b0};
    rows[4] = {12'h020, 1'b1, 32'h0000_0055, 32'h0, 1'b1};
    rows[5] = {12'hFFC, 1'b0, 32'h0, 32'h0, 1'b1};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 8; i = i + 1) begin
      rdi(12'(4 * i));
      chk("reset value", 32'h0, rd);
    end
    for (i = 0; i < 6; i = i + 1) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rdi(rows[i].a);
      chk("read data", rows[i].e, rd);
      chk("slave error", {31'h0, rows[i].s}, {31'h0, er});
    end
    wr(`TPGWC_OFF_PERIOD, 32'h9);
    wr(`TPGWC_OFF_WIDTH, 32'h3);
    wr(`TPGWC_OFF_MODE, {30'h0, `TPGWC_MODE_MATCH});
    meas;
    chk("ppg high", 32'd4, hi);
    chk("ppg period", 32'd10, hi + lo);
    wr(`TPGWC_OFF_MODE, {30'h0, `TPGWC_MODE_FREE});
    apb(`TPGWC_OFF_COUNT, 1'b0, 32'h0);
    hi = rd;
    rdi(`TPGWC_OFF_COUNT);
    chk("count step", 32'h2, rd - hi);
    repeat (65540) @(posedge pclk);
    rdi(`TPGWC_OFF_STATUS);
    chk("overflow", 32'h1, rd & 32'h1);
    wr(`TPGWC_OFF_STATUS, 32'h1);
    rdi(`TPGWC_OFF_STATUS);
    chk("overflow clear", 32'h0, rd & 32'h1);
    wr(`TPGWC_OFF_CAPCTL, 32'h7D);
    hi_len <= 8'd6;
    lo_len <= 8'd6;
    go <= 1'b1;
    repeat (30) @(posedge pclk);
    go <= 1'b0;
    apb(`TPGWC_OFF_PERIOD, 1'b0, 32'h0);
    hi = rd;
    rdi(`TPGWC_OFF_WIDTH);
    chk("two-input span", 32'h5, (hi - rd) & 32'hFFFF);
    wr(`TPGWC_OFF_MODE, {30'h0, `TPGWC_MODE_STOP});
    wr(`TPGWC_OFF_CAPCTL, 32'h0F);
    wr(`TPGWC_OFF_MODE, {30'h0, `TPGWC_MODE_EDGE});
    hi_len <= 8'd4;
    lo_len <= 8'd7;
    reps <= 4'h3;
    go <= 1'b1;
    repeat (45) @(posedge pclk);
    go <= 1'b0;
    apb(`TPGWC_OFF_WIDTH, 1'b0, 32'h0);
    hi = rd;
    rdi(`TPGWC_OFF_PERIOD);
    chk("low span", 32'h7, (hi - rd) & 32'hFFFF);
    rdi(`TPGWC_OFF_STATUS);
    chk("edge no overflow", 32'h0, rd & 32'h1);
    wr(`TPGWC_OFF_MODE, {30'h0, `TPGWC_MODE_STOP});
    wr(`TPGWC_OFF_CAPCTL, 32'h0);
    wr(`TPGWC_OFF_PERIOD, 32'd20);
    wr(`TPGWC_OFF_WIDTH, 32'd8);
    wr(`TPGWC_OFF_OUTCTL, 32'hF);
    wr(`TPGWC_OFF_STATUS, 32'h7);
    wr(`TPGWC_OFF_MODE, {30'h0, `TPGWC_MODE_FREE});
    wr(`TPGWC_OFF_SOFTTRIG, 32'h1);
    meas;
    chk("one-shot width", 32'd12, hi);
    rdi(`TPGWC_OFF_STATUS);
    chk("match events", 32'h6, rd & 32'h6);
    wr(`TPGWC_OFF_SOFTTRIG, 32'h1);
    meas;
    chk("second one-shot", 32'd12, hi);
    finish_test;
  end
endmodule // timer_pulse_gen_and_width_capture_test
